// >>> ext_int_latch.sv
/*
 External interrupt pin latch with its APB register slave.
 Assumes an APB master on mclk, a CPU that pulses vector_fetch while it
 fetches this vector, and a system break controller driving break_active.
*/
// Decided for this implementation: register access over APB and the register addresses.
// Behaviour
// RL1: Function works only while the enable bit is one; else pin is idle.
// RL2: A falling edge on the pin sets the request latch.
// RL3: Vector fetch produces an acknowledge that clears the latch.
// RL4: Writing one to write-only acknowledge bit 2 clears the latch.
// RL5: Reset clears latch and sensitivity bit even with the pin low.
// RL6: Edge-only after reset; software may add low-level sensitivity.
// RL7: Level mode keeps request while pin low; needs pin high and ack.
// RL8: Acknowledge and pin return high may come in either order.
// RL9: Acknowledge never blocks later edges; a new edge sets again.
// RL10: Edge mode: vector fetch or software ack clears at once.
// RL11: Mask bit 1 withholds the request from the priority logic.
// RL12: Pending flag bit 3 shows state regardless of the mask.
// RL13: Acknowledge bit and bits 7 to 4 read zero.
// RL14: Block runs in wait and stop; unmasked request wakes the CPU.
// RL15: In break, clears blocked unless break clear enable is one.
// RL16: Pin has an internal pullup so it idles high; code turns the pullup on only while the enable bit is one.
// RL17: Live pin level goes to branch-on-pin-high and low logic.
// RL18: Software should mask requests in the level-mode service routine.
// RL19: CPU global interrupt mask blocks this request too.
// RL20: Pin synchronised before edge detect; request gated by mask.
`timescale 1ns/1ps
`include "ext_int_regs.svh"
module ext_int_latch (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`EIRQ_ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_int_pin,
   output logic ext_int_pullup_en,
   input wire logic vector_fetch,
   input wire logic break_active,
   input wire logic cpu_global_mask,
   output logic irq_request,
   output logic wake_request,
   output logic pin_level_for_branch
);
   import ext_int_pkg::*;

   pin_sync_if sif();

   logic latch_q;
   logic latch_d;
   logic sense_q;
   logic sense_d;
   logic mask_q;
   logic mask_d;
   logic enable_q;
   logic enable_d;
   logic brk_clr_q;
   logic brk_clr_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pslverr_q;
   logic pslverr_d;
   logic acc_q;
   logic acc_d;
   ext_int_pkg::apb_phase_t phase;

   logic wr_en;
   logic rd_en;
   logic sel_sc;
   logic sel_cfg;
   logic sel_pin;
   logic sw_ack;
   logic any_ack;
   logic clear_ok;
   logic pin_low;
   logic fall_evt;
   logic pending;

   function automatic logic addr_hit(
      input logic [`EIRQ_ADDR_WIDTH-1:0] a,
      input logic [`EIRQ_ADDR_WIDTH-1:0] off
   );
      addr_hit = (a == off);
   endfunction

   // Pullup held on while enabled so a floating pin reads high
   assign ext_int_pullup_en = enable_q; // [RL16]
   // Disabled function presents a high pin so no edge is seen
   assign sif.pin_raw = enable_q ? ext_int_pin : 1'b1; // [RL1]

   pin_sync u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .sif(sif)
   ); // [RL20]

   assign pin_low = ~sif.pin_level;
   assign fall_evt = sif.pin_fall;
   assign pin_level_for_branch = sif.pin_level; // [RL17]

   // APB decode; zero wait state, answer in the first access cycle
   assign wr_en = (phase == apb_access_st) & pwrite & ~acc_q;
   assign rd_en = (phase == apb_setup_st) & ~pwrite;
   assign sel_sc = addr_hit(paddr, `EIRQ_STATUS_CONTROL_OFFSET);
   assign sel_cfg = addr_hit(paddr, `EIRQ_CONFIG_OFFSET);
   assign sel_pin = addr_hit(paddr, `EIRQ_PIN_STATUS_OFFSET);
   assign phase = !psel ? apb_idle_st : (penable ? apb_access_st
                                                  : apb_setup_st);
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   assign sw_ack = wr_en & sel_sc & pwdata[`EIRQ_ACK_BIT]; // [RL4]
   // Break state blocks acknowledge clears of the flag unless clearing is enabled
   assign clear_ok = ~break_active | brk_clr_q; // [RL15]
   assign any_ack = (vector_fetch | sw_ack) & clear_ok; // [RL3] [RL10]
   // Level mode: pin term holds the request; ack and release in any order
   assign pending = latch_q | (sense_q & pin_low & enable_q); // [RL7] [RL8]

   always_comb begin
      latch_d = latch_q;
      // Ack drops the latch unless an edge sets it in the same cycle; in level mode a low pin still holds pending
      if (any_ack) begin
         latch_d = 1'b0; // [RL10] [RL8]
      end
      // Set wins over a clear in the same cycle
      if (fall_evt && enable_q) begin
         latch_d = 1'b1; // [RL2] [RL9]
      end
      if (!enable_q) begin
         latch_d = 1'b0; // [RL1]
      end
   end

   always_comb begin
      sense_d = sense_q;
      mask_d = mask_q;
      enable_d = enable_q;
      brk_clr_d = brk_clr_q;
      if (wr_en && sel_sc) begin
         sense_d = pwdata[`EIRQ_SENSE_BIT]; // [RL6]
         mask_d = pwdata[`EIRQ_MASK_BIT];
      end
      if (wr_en && sel_cfg) begin
         enable_d = pwdata[`EIRQ_ENABLE_BIT];
         brk_clr_d = pwdata[`EIRQ_BREAK_CLEAR_BIT];
      end
   end

   always_comb begin
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      acc_d = psel & penable;
      if (rd_en) begin
         prdata_d = 32'h0;
         if (sel_sc) begin
            prdata_d[`EIRQ_PENDING_BIT] = pending; // [RL12] [RL13]
            prdata_d[`EIRQ_MASK_BIT] = mask_q;
            prdata_d[`EIRQ_SENSE_BIT] = sense_q;
         end else if (sel_cfg) begin
            prdata_d[`EIRQ_ENABLE_BIT] = enable_q;
            prdata_d[`EIRQ_BREAK_CLEAR_BIT] = brk_clr_q;
         end else if (sel_pin) begin
            prdata_d[`EIRQ_PIN_LEVEL_BIT] = sif.pin_level;
         end
      end
      if (phase == apb_setup_st && !(sel_sc || sel_cfg || sel_pin)) begin
         pslverr_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         latch_q <= 1'b0; // [RL5]
         sense_q <= 1'b0; // [RL5] [RL6]
         mask_q <= 1'b0;
         enable_q <= 1'b0;
         brk_clr_q <= 1'b0;
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
         acc_q <= 1'b0;
      end else begin
         latch_q <= latch_d;
         sense_q <= sense_d;
         mask_q <= mask_d;
         enable_q <= enable_d;
         brk_clr_q <= brk_clr_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
         acc_q <= acc_d;
      end
   end

   // Wake path ignores the CPU global mask; only the local mask gates it
   assign wake_request = pending & ~mask_q; // [RL14] [RL11]
   assign irq_request = pending & ~mask_q & ~cpu_global_mask; // [RL11] [RL19]

   property p_fall_sets;
      @(posedge mclk) disable iff (!rstn)
      fall_evt && enable_q |=> latch_q;
   endproperty
   a_fall_sets: assert property (p_fall_sets) // [RL2]
      else $error("falling edge did not set latch");

   property p_ack_clears;
      @(posedge mclk) disable iff (!rstn)
      sw_ack && !sense_q && !fall_evt && clear_ok && enable_q |=> !latch_q;
   endproperty
   a_ack_clears: assert property (p_ack_clears) // [RL4]
      else $error("software ack did not clear latch");

   property p_fetch_clears;
      @(posedge mclk) disable iff (!rstn)
      vector_fetch && !sense_q && !fall_evt && clear_ok |=> !latch_q;
   endproperty
   a_fetch_clears: assert property (p_fetch_clears) // [RL3]
      else $error("vector fetch did not clear latch");

   property p_level_holds;
      @(posedge mclk) disable iff (!rstn)
      sense_q && pin_low && enable_q && !mask_q && !cpu_global_mask
         |-> irq_request;
   endproperty
   a_level_holds: assert property (p_level_holds) // [RL7]
      else $error("level mode request dropped while pin low");

   // Ack before release must not leave a stale latch behind
   property p_level_ack;
      @(posedge mclk) disable iff (!rstn)
      sense_q && any_ack && !fall_evt |=> !latch_q;
   endproperty
   a_level_ack: assert property (p_level_ack) // [RL8]
      else $error("level mode ack did not clear latch");

   property p_edge_only;
      @(posedge mclk) disable iff (!rstn)
      !sense_q && latch_q && any_ack && !fall_evt |=> !pending;
   endproperty
   a_edge_only: assert property (p_edge_only) // [RL10]
      else $error("edge mode ack left request pending");

   property p_set_wins;
      @(posedge mclk) disable iff (!rstn)
      fall_evt && enable_q && any_ack |=> latch_q;
   endproperty
   a_set_wins: assert property (p_set_wins) // [RL9]
      else $error("edge lost against a same cycle ack");

   // No disable here: this one watches the reset itself
   property p_reset_clears;
      @(posedge mclk)
      !rstn |=> !latch_q && !sense_q && !mask_q && !irq_request;
   endproperty
   a_reset_clears: assert property (p_reset_clears) // [RL5]
      else $error("reset left request or mode set");

   property p_mask_blocks;
      @(posedge mclk) disable iff (!rstn)
      mask_q |-> !irq_request && !wake_request;
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) // [RL11]
      else $error("masked request reached output");

   property p_wake_path;
      @(posedge mclk) disable iff (!rstn)
      pending && !mask_q && cpu_global_mask |-> wake_request;
   endproperty
   a_wake_path: assert property (p_wake_path) // [RL14]
      else $error("unmasked request did not raise wake");

   property p_break_protect;
      @(posedge mclk) disable iff (!rstn)
      break_active && !brk_clr_q && latch_q && enable_q |=> latch_q;
   endproperty
   a_break_protect: assert property (p_break_protect) // [RL15]
      else $error("flag cleared during protected break");

   property p_disabled_idle;
      @(posedge mclk) disable iff (!rstn)
      !enable_q ##1 !enable_q |-> !latch_q && !irq_request;
   endproperty
   a_disabled_idle: assert property (p_disabled_idle) // [RL1]
      else $error("request while function disabled");

   property p_sc_read;
      @(posedge mclk) disable iff (!rstn)
      rd_en && sel_sc |=> prdata[7:4] == 4'h0 && !prdata[2]
                          && prdata[3] == $past(pending);
   endproperty
   a_sc_read: assert property (p_sc_read) // [RL12] [RL13]
      else $error("status read wrong");

   property p_global_mask;
      @(posedge mclk) disable iff (!rstn)
      cpu_global_mask |-> !irq_request;
   endproperty
   a_global_mask: assert property (p_global_mask) // [RL19]
      else $error("global mask ignored");

   c_edge_irq: cover property (@(posedge mclk) disable iff (!rstn)
      fall_evt ##1 irq_request);
   c_level_ack: cover property (@(posedge mclk) disable iff (!rstn)
      sense_q && pin_low && sw_ack ##[1:20] !pending);
   c_break_hold: cover property (@(posedge mclk) disable iff (!rstn)
      break_active && latch_q && vector_fetch);
   c_ack_before_release: cover property (@(posedge mclk) disable iff (!rstn)
      sense_q && pending && !latch_q ##[1:40] !pending);
endmodule // ext_int_latch

// >>> ext_int_pkg.sv
/*
 Types shared by the external interrupt pin latch and its synchroniser.
 Assumes the register header sits in the include path.
*/
package ext_int_pkg;
   `include "ext_int_regs.svh"

   typedef enum logic [1:0] {
      apb_idle_st = 2'b00,
      apb_setup_st = 2'b01,
      apb_access_st = 2'b10
   } apb_phase_t;

   typedef logic [7:0] reg_byte_t;
endpackage

// >>> ext_int_regs.svh
/*
 Register offsets, field positions, reset values and timing constants for the
 external interrupt pin latch.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef EXT_INT_REGS_SVH
`define EXT_INT_REGS_SVH

`define EIRQ_STATUS_CONTROL_OFFSET 12'h000
`define EIRQ_CONFIG_OFFSET 12'h004
`define EIRQ_PIN_STATUS_OFFSET 12'h008
`define EIRQ_ADDR_WIDTH 12

`define EIRQ_SENSE_BIT 0
`define EIRQ_MASK_BIT 1
`define EIRQ_ACK_BIT 2
`define EIRQ_PENDING_BIT 3
`define EIRQ_ENABLE_BIT 0
`define EIRQ_BREAK_CLEAR_BIT 1
`define EIRQ_PIN_LEVEL_BIT 0

`define EIRQ_STATUS_CONTROL_RESET 8'h00
`define EIRQ_CONFIG_RESET 8'h00
`define EIRQ_SYNC_STAGES 3

`endif

// >>> ext_pin_source.sv
/*
 External interrupt source that drives the active-low pin.
 Assumes the device pullup enable shows whether the line is pulled high.
*/
`timescale 1ns/1ps
module ext_pin_source (
   input wire logic mclk,
   input wire logic pull_low,
   input wire logic pullup_en,
   output logic pin
);
   logic float_q = 1'b0;

   // A released line with no pullup floats; toggling keeps it from settling
   always_ff @(posedge mclk) begin
      float_q <= ~float_q;
   end

   assign pin = pull_low ? 1'b0 : (pullup_en ? 1'b1 : float_q);
endmodule // ext_pin_source

// >>> pin_sync.sv
/*
 Three-stage pin synchroniser with edge detection on the agreeing stages.
 Assumes the pin is asynchronous to mclk; reset is synchronous, active low.
*/
`timescale 1ns/1ps
module pin_sync (
   input wire logic mclk,
   input wire logic rstn,
   pin_sync_if.sync_side sif
);
   import ext_int_pkg::*;

   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic level_q;
   logic level_d;

   // Idle high so reset never looks like a falling edge
   always_comb begin
      stage_d = {stage_q[1:0], sif.pin_raw};
      level_d = level_q;
      if (stage_q[2] == stage_q[1]) begin
         level_d = stage_q[1];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         stage_q <= 3'h7;
         level_q <= 1'b1;
      end else begin
         stage_q <= stage_d;
         level_q <= level_d;
      end
   end

   assign sif.pin_level = level_q;
   assign sif.pin_fall = level_q & ~level_d;
endmodule // pin_sync

// >>> pin_sync_if.sv
/*
 Carries the raw pin into the synchroniser and the settled level and falling
 edge back to the latch.
 Assumes a single clock domain on mclk.
*/
`timescale 1ns/1ps
interface pin_sync_if;
   logic pin_raw;
   logic pin_level;
   logic pin_fall;
   modport sync_side (
      input pin_raw,
      output pin_level,
      output pin_fall
   );
   modport user_side (
      output pin_raw,
      input pin_level,
      input pin_fall
   );
endinterface

// >>> tb_top.sv
/*
 Self-checking bench for the external interrupt pin latch.
 Assumes the package, header, design and pin source model compile first.
*/
`timescale 1ns/1ps
`include "ext_int_regs.svh"
module tb_top;
   import ext_int_pkg::*;
   localparam logic [11:0] scr_a = `EIRQ_STATUS_CONTROL_OFFSET;
   localparam logic [11:0] cfg_a = `EIRQ_CONFIG_OFFSET;
   logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pull_low = 1'b0, vector_fetch = 1'b0;
   logic break_active = 1'b0, cpu_global_mask = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, slv, pin, pullup_en;
   logic irq_request, wake_request, pin_level;
   int mismatches = 0, n_tests = 0, cycles = 0;
   reg_byte_t w;

   initial begin
      forever #25 mclk = ~mclk;
   end

   ext_int_latch DUT (.mclk(mclk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_int_pin(pin), .ext_int_pullup_en(pullup_en),
      .vector_fetch(vector_fetch), .break_active(break_active),
      .cpu_global_mask(cpu_global_mask), .irq_request(irq_request),
      .wake_request(wake_request), .pin_level_for_branch(pin_level));

   ext_pin_source src (.mclk(mclk), .pull_low(pull_low),
      .pullup_en(pullup_en), .pin(pin));

   function automatic logic [31:0] scr_exp(logic pend, logic m, logic s);
      return {28'h0, pend, 1'b0, m, s};
   endfunction

   function automatic logic irq_exp(logic pend, logic m, logic gm);
      return pend & ~m & ~gm;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Request holds until pready is seen high at a rising edge; answer
   // values are taken at that same edge, before the design updates them
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [31:0] e);
      apb(1'b0, scr_a, 32'h0);
      check(rd, e);
   endtask

   task automatic drive_pin(input logic low);
      @(posedge mclk);
      pull_low <= low;
      repeat (8) @(posedge mclk);
   endtask

   task automatic fetch();
      @(posedge mclk);
      vector_fetch <= 1'b1;
      @(posedge mclk);
      vector_fetch <= 1'b0;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end

   initial begin
      void'($urandom(32'h44a9));
      repeat (20) @(posedge mclk);
      check(pin_level, 1'b1);
      check(pullup_en, 1'b0);
      rstn <= 1'b1;
      rchk(scr_exp(0, 0, 0));
      drive_pin(1'b1);
      rchk(scr_exp(0, 0, 0));
      drive_pin(1'b0);
      apb(1'b1, cfg_a, 32'h1);
      repeat (8) @(negedge mclk);
      check(pullup_en, 1'b1);
      check(pin_level, 1'b1);
      drive_pin(1'b1);
      @(negedge mclk);
      check(pin_level, 1'b0);
      check(irq_request, irq_exp(1, 0, 0));
      check(wake_request, 1'b1);
      apb(1'b1, scr_a, 32'h2);
      @(negedge mclk);
      check(irq_request, irq_exp(1, 1, 0));
      check(wake_request, 1'b0);
      rchk(scr_exp(1, 1, 0));
      apb(1'b1, scr_a, 32'h0);
      cpu_global_mask <= 1'b1;
      @(negedge mclk);
      check(irq_request, irq_exp(1, 0, 1));
      @(posedge mclk);
      cpu_global_mask <= 1'b0;
      apb(1'b1, scr_a, 32'h4);
      rchk(scr_exp(0, 0, 0));
      drive_pin(1'b0);
      drive_pin(1'b1);
      rchk(scr_exp(1, 0, 0));
      fetch();
      @(negedge mclk);
      check(irq_request, 1'b0);
      drive_pin(1'b0);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, scr_a, 32'h1);
         drive_pin(1'b1);
         rchk(scr_exp(1, 0, 1));
         // Pass 0 acks while low; pass 1 masks in service, acks later
         apb(1'b1, scr_a, (i == 0) ? 32'h5 : 32'h3);
         rchk(scr_exp(1, i[0], 1));
         drive_pin(1'b0);
         rchk(scr_exp(i[0], i[0], 1));
         if (i == 1) begin
            fetch();
         end
         rchk(scr_exp(0, i[0], 1));
      end
      apb(1'b1, scr_a, 32'h0);
      drive_pin(1'b1);
      break_active <= 1'b1;
      apb(1'b1, scr_a, 32'h4);
      fetch();
      rchk(scr_exp(1, 0, 0));
      apb(1'b1, cfg_a, 32'h3);
      apb(1'b1, scr_a, 32'h4);
      break_active <= 1'b0;
      apb(1'b1, cfg_a, 32'h1);
      rchk(scr_exp(0, 0, 0));
      drive_pin(1'b0);
      apb(1'b0, 12'h0f0, 32'h0);
      check(slv, 1'b1);
      check(rd, 32'h0);
      repeat (8) begin
         w = reg_byte_t'($urandom);
         cpu_global_mask <= w[7];
         apb(1'b1, scr_a, {24'h0, w});
         rchk(scr_exp(0, w[1], w[0]));
         drive_pin(1'b1);
         @(negedge mclk);
         check(irq_request, irq_exp(1, w[1], w[7]));
         check(wake_request, irq_exp(1, w[1], 0));
         drive_pin(1'b0);
         apb(1'b1, scr_a, {29'h0, 1'b1, w[1:0]});
         rchk(scr_exp(0, w[1], w[0]));
      end
      cpu_global_mask <= 1'b0;
      apb(1'b1, scr_a, 32'h1);
      drive_pin(1'b1);
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rchk(scr_exp(0, 0, 0));
      @(negedge mclk);
      check(irq_request, 1'b0);
      give_verdict();
   end
endmodule // tb_top
